// ---- logic/tsense_top.sv ----
// Purpose: Conversion control, result FIFO, pin roles and registers
// Assumes: TEMP_RAW is the sensor front end's word, valid at conversion end
// Notes: registers on AHB-Lite, zero wait states, always OKAY
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module tsense_top import tsense_pkg::*; #(
  parameter int CONVERSION_TRIGGER_IN_CYCLES_P = CONVERSION_TRIGGER_IN_CYCLES,
  parameter int SAMPLE_CYCLES_P = SLOT_SAMPLE_CYCLES,
  parameter int DEPTH = FIFO_DEPTH,
  // Arbitrary value, replaced per part at trim
  parameter logic [63:0] SERIAL_CODE = 64'h5a3c_0f96_1e2d_4b78
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Single-wire data line
  input wire logic DQ_IN,
  output logic DQ_OUT,
  output logic DQ_OE,
  // General pins
  input wire logic GENERAL_PIN_ZERO_IN,
  output logic GENERAL_PIN_ZERO_OUT,
  output logic GENERAL_PIN_ZERO_OE,
  input wire logic GENERAL_PIN_ONE_IN,
  output logic GENERAL_PIN_ONE_OUT,
  output logic GENERAL_PIN_ONE_OE,
  input wire logic GENERAL_PIN_TWO_IN,
  output logic GENERAL_PIN_TWO_OUT,
  output logic GENERAL_PIN_TWO_OE,
  output logic [2:0] PIN_PULLDOWN_EN,
  // Sensor front end
  input wire logic [15:0] TEMP_RAW,
  output logic SENSE_EN
);
  localparam int PW = $clog2(DEPTH);

  function automatic logic is_special(input logic [1:0] role);
    is_special = (role == ROLE_SPECIAL);
  endfunction

  logic rst_meta_ff;
  logic rst_n;
  logic [3:0] in_s1_ff;
  logic [3:0] in_s2_ff;
  logic [3:0] in_s3_ff;
  logic [3:0] in_filt_ff;
  logic [3:0] agree;
  logic pin_one_prev_ff;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  conversion_trigger_in_state_t state_ff;
  logic [31:0] conversion_trigger_in_cnt_ff;
  logic conversion_trigger_in_done;
  logic trig_cmd;
  logic trig_pin;
  logic trig_sw;
  logic trig_any;
  logic [15:0] fifo_mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] count_ff;
  logic fifo_full;
  logic fifo_empty;
  logic push;
  logic pop;
  logic [15:0] result;
  logic [1:0] int_en_ff;
  logic [5:0] pin_setup_ff;
  logic [2:0] pin_out_ff;
  logic [15:0] upper_thr_ff;
  logic [15:0] lower_thr_ff;
  logic temp_hi_ff;
  logic temp_lo_ff;
  logic alarm_flag;
  logic irq_out_n;
  logic acc_phase;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] rd_addr;
  logic [31:0] rd_mux;
  logic [31:0] rdata_ff;
  logic sw_start_ff;
  logic [2:0] pin_oe_ff;
  logic [2:0] pd_ff;
  logic status_rd;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // Pins and data line: three flops, a change counts when stages two and three agree
  assign agree = ~(in_s2_ff ^ in_s3_ff);
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_ff <= 4'h1;
      in_s2_ff <= 4'h1;
      in_s3_ff <= 4'h1;
      in_filt_ff <= 4'h1;
    end else begin
      in_s1_ff <= {GENERAL_PIN_TWO_IN, GENERAL_PIN_ONE_IN, GENERAL_PIN_ZERO_IN, DQ_IN};
      in_s2_ff <= in_s1_ff;
      in_s3_ff <= in_s2_ff;
      in_filt_ff <= (in_s3_ff & agree) | (in_filt_ff & ~agree);
    end
  end

  cmd_rx #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES_P)
  ) cmd_rx_i (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .line_lvl(in_filt_ff[0]),
    .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte)
  );

  // data line never driven high; released in this block
  assign DQ_OUT = 1'b0;
  assign DQ_OE = 1'b0;

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_one_prev_ff <= 1'b0;
    end else begin
      pin_one_prev_ff <= in_filt_ff[2];
    end
  end

  assign trig_cmd = cmd_valid && (cmd_byte == CMD_CONVERT);
  // pin one rising edge, special role only
  assign trig_pin = is_special(pin_setup_ff[3:2]) && in_filt_ff[2] && !pin_one_prev_ff;
  assign trig_sw = sw_start_ff;
  assign trig_any = trig_cmd || trig_pin || trig_sw;
  assign conversion_trigger_in_done = (state_ff == CONVERTING) && (conversion_trigger_in_cnt_ff == 32'(CONVERSION_TRIGGER_IN_CYCLES_P - 1));

  // standby until triggered; triggers while busy are dropped
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= STANDBY;
      conversion_trigger_in_cnt_ff <= 32'h0000_0000;
    end else begin
      unique case (state_ff)
        STANDBY: begin
          conversion_trigger_in_cnt_ff <= 32'h0000_0000;
          if (trig_any) begin
            state_ff <= CONVERTING;
          end
        end
        CONVERTING: begin
          if (conversion_trigger_in_done) begin
            state_ff <= STANDBY;
          end else begin
            conversion_trigger_in_cnt_ff <= conversion_trigger_in_cnt_ff + 32'h0000_0001;
          end
        end
      endcase
    end
  end
  assign SENSE_EN = (state_ff == CONVERTING);

  // front end word kept as is: signed 0.005 C counts, bit 15 sign
  assign result = TEMP_RAW;
  assign push = conversion_trigger_in_done;
  assign fifo_full = (count_ff == (PW + 1)'(DEPTH));
  assign fifo_empty = (count_ff == '0);

  // circular store; a push at full drops the oldest
  always_ff @(posedge CORE_CLK) begin
    if (push) begin
      fifo_mem[wr_ptr_ff] <= result;
    end
  end
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + PW'(1);
      end
      if (pop || (push && fifo_full)) begin
        rd_ptr_ff <= rd_ptr_ff + PW'(1);
      end
      if (push && !pop && !fifo_full) begin
        count_ff <= count_ff + (PW + 1)'(1);
      end else if (pop && !push) begin
        count_ff <= count_ff - (PW + 1)'(1);
      end
    end
  end

  // Alarm bits: a new event wins over a status read in the same cycle
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      temp_hi_ff <= 1'b0;
      temp_lo_ff <= 1'b0;
    end else begin
      temp_hi_ff <= (push && ($signed(result) > $signed(upper_thr_ff))) || (temp_hi_ff && !status_rd);
      temp_lo_ff <= (push && ($signed(result) < $signed(lower_thr_ff))) || (temp_lo_ff && !status_rd);
    end
  end
  assign alarm_flag = (temp_hi_ff && int_en_ff[0]) || (temp_lo_ff && int_en_ff[1]);
  // active-low interrupt only in the special role
  assign irq_out_n = !(is_special(pin_setup_ff[1:0]) && alarm_flag);

  // pin drive registered; output role only ever pulls low
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_ff <= 3'h0;
      pd_ff <= 3'h7;
    end else begin
      for (int i = 0; i < 3; i++) begin
        pin_oe_ff[i] <= (pin_setup_ff[2*i +: 2] == ROLE_OUTPUT) && !pin_out_ff[i];
        pd_ff[i] <= (pin_setup_ff[2*i +: 2] == ROLE_PULLDOWN);
      end
      pin_oe_ff[0] <= ((pin_setup_ff[1:0] == ROLE_OUTPUT) && !pin_out_ff[0]) || !irq_out_n;
    end
  end
  assign GENERAL_PIN_ZERO_OUT = 1'b0;
  assign GENERAL_PIN_ONE_OUT = 1'b0;
  assign GENERAL_PIN_TWO_OUT = 1'b0;
  assign GENERAL_PIN_ZERO_OE = pin_oe_ff[0];
  assign GENERAL_PIN_ONE_OE = pin_oe_ff[1];
  assign GENERAL_PIN_TWO_OE = pin_oe_ff[2];
  assign PIN_PULLDOWN_EN = pd_ff;

  // AHB-Lite: zero wait states, reads decoded in the address phase
  assign acc_phase = HSEL && HTRANS[1] && HREADY;
  assign rd_addr = HADDR[7:0];
  assign pop = acc_phase && !HWRITE && (rd_addr == FIFO_DATA_OFS) && !fifo_empty;
  assign status_rd = acc_phase && !HWRITE && (rd_addr == STATUS_OFS);
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_ff;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (rd_addr)
      STATUS_OFS: begin
        rd_mux[ST_BUSY] = (state_ff == CONVERTING);
        rd_mux[ST_HI] = temp_hi_ff;
        rd_mux[ST_LO] = temp_lo_ff;
        rd_mux[ST_EMPTY] = fifo_empty;
      end
      INT_EN_OFS: rd_mux[1:0] = int_en_ff;
      PIN_SETUP_OFS: rd_mux[5:0] = pin_setup_ff;
      PIN_OUT_OFS: rd_mux[2:0] = pin_out_ff;
      PIN_LEVEL_OFS: rd_mux[2:0] = in_filt_ff[3:1];
      FIFO_DATA_OFS: rd_mux[15:0] = fifo_empty ? 16'h0000 : fifo_mem[rd_ptr_ff];
      FIFO_COUNT_OFS: rd_mux[PW:0] = count_ff;
      UPPER_THR_OFS: rd_mux[15:0] = upper_thr_ff;
      LOWER_THR_OFS: rd_mux[15:0] = lower_thr_ff;
      SERIAL_LO_OFS: rd_mux = SERIAL_CODE[31:0];
      SERIAL_HI_OFS: rd_mux = SERIAL_CODE[63:32];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= acc_phase && HWRITE;
      if (acc_phase) begin
        wr_addr_ff <= rd_addr;
        rdata_ff <= HWRITE ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // thresholds are plain registers, back to defaults at every reset
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      int_en_ff <= INT_EN_RST;
      pin_setup_ff <= PIN_SETUP_RST;
      pin_out_ff <= PIN_OUT_RST;
      upper_thr_ff <= UPPER_THR_RST;
      lower_thr_ff <= LOWER_THR_RST;
      sw_start_ff <= 1'b0;
    end else begin
      sw_start_ff <= wr_pend_ff && (wr_addr_ff == CTRL_OFS) && HWDATA[CTRL_START];
      if (wr_pend_ff) begin
        unique case (wr_addr_ff)
          INT_EN_OFS: int_en_ff <= HWDATA[1:0];
          PIN_SETUP_OFS: pin_setup_ff <= HWDATA[5:0];
          PIN_OUT_OFS: pin_out_ff <= HWDATA[2:0];
          UPPER_THR_OFS: upper_thr_ff <= HWDATA[15:0];
          LOWER_THR_OFS: lower_thr_ff <= HWDATA[15:0];
          default: ;
        endcase
      end
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!rst_n);

  chk_cmd_starts_conversion_trigger_in: assert property (
    (state_ff == STANDBY) && trig_cmd |=> (state_ff == CONVERTING) && (conversion_trigger_in_cnt_ff == 32'h0000_0000))
    else $error("convert command did not start a conversion");
  chk_pin_edge_start: assert property (
    (state_ff == STANDBY) && in_filt_ff[2] && !pin_one_prev_ff && is_special(pin_setup_ff[3:2])
    |=> state_ff == CONVERTING)
    else $error("pin one edge did not start a conversion");
  chk_pin_role_gate: assert property (
    (state_ff == STANDBY) && !is_special(pin_setup_ff[3:2]) && !trig_cmd && !trig_sw
    |=> state_ff == STANDBY)
    else $error("conversion started without any enabled trigger");
  chk_done_push_idle: assert property (
    (state_ff == CONVERTING) && (conversion_trigger_in_cnt_ff == 32'(CONVERSION_TRIGGER_IN_CYCLES_P - 1))
    |-> push ##1 (state_ff == STANDBY) && !SENSE_EN)
    else $error("conversion end did not store and return to standby");
  chk_busy_ignore: assert property (
    (state_ff == CONVERTING) && trig_any && !conversion_trigger_in_done
    |=> (state_ff == CONVERTING) && (conversion_trigger_in_cnt_ff == $past(conversion_trigger_in_cnt_ff) + 32'h0000_0001))
    else $error("trigger restarted a running conversion");
  chk_fifo_bound: assert property (
    count_ff <= (PW + 1)'(DEPTH))
    else $error("fifo count beyond depth");
  chk_full_overwrite: assert property (
    push && fifo_full && !pop |=> fifo_full && (rd_ptr_ff == $past(rd_ptr_ff) + PW'(1)))
    else $error("push at full did not drop the oldest entry");
  chk_irq_role: assert property (
    is_special(pin_setup_ff[1:0]) && $stable(pin_setup_ff) && $stable(alarm_flag)
    |=> GENERAL_PIN_ZERO_OE == $past(alarm_flag))
    else $error("pin zero interrupt disagrees with alarm flag");
  chk_standby_quiet: assert property (
    (state_ff == STANDBY) && !trig_any |=> !SENSE_EN && !push)
    else $error("activity in standby without a trigger");
  chk_line_released: assert property (
    !DQ_OE && !DQ_OUT)
    else $error("data line driven");

  cov_cmd_conversion_trigger_in: cover property (trig_cmd && (state_ff == STANDBY));
  cov_pin_conversion_trigger_in: cover property (trig_pin && (state_ff == STANDBY));
  cov_overwrite: cover property (push && fifo_full);
  cov_alarm_irq: cover property (!irq_out_n && GENERAL_PIN_ZERO_OE);
endmodule

// ---- logic/tsense_pkg.sv ----
// Purpose: Shared constants and types for the temperature conversion path
// Assumes: 250 MHz core clock, AHB-Lite register access
package tsense_pkg;
  localparam int CLK_MHZ = 250;
  localparam int CONVERSION_TRIGGER_IN_TIME_US = 16000;
  localparam int CONVERSION_TRIGGER_IN_CYCLES = CONVERSION_TRIGGER_IN_TIME_US * CLK_MHZ;
  localparam int SLOT_SAMPLE_NS = 30000;
  localparam int SLOT_SAMPLE_CYCLES = SLOT_SAMPLE_NS * CLK_MHZ / 1000;
  localparam int FIFO_DEPTH = 32;
  localparam logic [7:0] CMD_CONVERT = 8'h44;

  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] INT_EN_OFS = 8'h04;
  localparam logic [7:0] PIN_SETUP_OFS = 8'h08;
  localparam logic [7:0] PIN_OUT_OFS = 8'h0c;
  localparam logic [7:0] PIN_LEVEL_OFS = 8'h10;
  localparam logic [7:0] FIFO_DATA_OFS = 8'h14;
  localparam logic [7:0] FIFO_COUNT_OFS = 8'h18;
  localparam logic [7:0] UPPER_THR_OFS = 8'h1c;
  localparam logic [7:0] LOWER_THR_OFS = 8'h20;
  localparam logic [7:0] SERIAL_LO_OFS = 8'h24;
  localparam logic [7:0] SERIAL_HI_OFS = 8'h28;
  localparam logic [7:0] CTRL_OFS = 8'h2c;

  localparam int ST_BUSY = 0;
  localparam int ST_HI = 1;
  localparam int ST_LO = 2;
  localparam int ST_EMPTY = 3;
  localparam int CTRL_START = 0;

  localparam logic [5:0] PIN_SETUP_RST = 6'h2a;
  localparam logic [2:0] PIN_OUT_RST = 3'h7;
  localparam logic [1:0] INT_EN_RST = 2'h0;
  localparam logic [15:0] UPPER_THR_RST = 16'h7fff;
  localparam logic [15:0] LOWER_THR_RST = 16'h8000;

  localparam logic [1:0] ROLE_INPUT = 2'h0;
  localparam logic [1:0] ROLE_OUTPUT = 2'h1;
  localparam logic [1:0] ROLE_PULLDOWN = 2'h2;
  localparam logic [1:0] ROLE_SPECIAL = 2'h3;

  typedef enum logic {STANDBY, CONVERTING} conversion_trigger_in_state_t;
endpackage

// ---- logic/cmd_rx.sv ----
// Purpose: Collects write slots on the data line into command bytes
// Assumes: line level already synchronised and filtered
// Notes: no reset-pulse or ROM handling; every eight slots form a byte
`timescale 1ns/1ns
module cmd_rx import tsense_pkg::*; #(
  parameter int SAMPLE_CYCLES = SLOT_SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Line
  input wire logic line_lvl,
  // Byte out
  output logic cmd_valid,
  output logic [7:0] cmd_byte
);
  logic line_prev_ff;
  logic slot_act_ff;
  logic [15:0] slot_cnt_ff;
  logic [7:0] shift_ff;
  logic [2:0] bits_ff;
  logic valid_ff;
  logic sample_now;

  assign sample_now = slot_act_ff && (slot_cnt_ff == 16'(SAMPLE_CYCLES - 1));
  assign cmd_valid = valid_ff;
  assign cmd_byte = shift_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_prev_ff <= 1'b1;
    end else begin
      line_prev_ff <= line_lvl;
    end
  end

  // A slot opens on the master's falling edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_act_ff <= 1'b0;
      slot_cnt_ff <= 16'h0000;
    end else if (!slot_act_ff && line_prev_ff && !line_lvl) begin
      slot_act_ff <= 1'b1;
      slot_cnt_ff <= 16'h0000;
    end else if (sample_now) begin
      slot_act_ff <= 1'b0;
    end else if (slot_act_ff) begin
      slot_cnt_ff <= slot_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= 8'h00;
      bits_ff <= 3'h0;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= sample_now && (bits_ff == 3'h7);
      if (sample_now) begin
        shift_ff <= {line_lvl, shift_ff[7:1]};
        bits_ff <= bits_ff + 3'h1;
      end
    end
  end

  chk_lsb_order: assert property (@(posedge clk) disable iff (!rst_n)
    valid_ff |-> (shift_ff[7] == $past(line_lvl)) && (shift_ff[6:0] == $past(shift_ff[7:1])))
    else $error("last slot bit not placed in byte msb");
endmodule

// ---- sim/wire_master_model.sv ----
// Purpose: Bus master model on the single-wire data line
// Assumes: write slots only, timing counted in core clock cycles
// Notes: no reset pulse or ROM layer, matching the receiver it drives
`timescale 1ns/1ns
module wire_master_model #(
  parameter int SAMPLE = 8
) (
  // Clock
  input wire logic clk,
  // Line
  input wire logic line_lvl,
  input wire logic converting,
  output logic drive_low,
  output logic strong_pullup
);
  initial drive_low = 1'b0;

  always_ff @(posedge clk) begin
    strong_pullup <= converting & line_lvl;
  end

  // slots sent LSB first
  // Low times sit well clear of the sample point, so filter jitter cannot flip a bit
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      drive_low <= 1'b1;
      repeat (b[i] ? 2 : SAMPLE + 10) @(posedge clk);
      drive_low <= 1'b0;
      repeat (SAMPLE + 20) @(posedge clk);
    end
  endtask
endmodule

// ---- sim/temp_conversion_result_path_test.sv ----
// Purpose: Self-checking bench for the temperature conversion path
// Assumes: short conversion and slot counts set through parameters
// Notes: expectations follow the register choices, never the design's outputs
`timescale 1ns/1ns
module temp_conversion_result_path_test import tsense_pkg::*; ();
  localparam int CONVERSION_TRIGGER_IN = 20;
  localparam int SAMPLE = 8;
  // Arbitrary value for simulation only
  localparam logic [63:0] SERIAL = 64'h0123_4567_89ab_cdef;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] temp_raw = 16'h0;
  logic [2:0] strap = 3'h0;
  logic [31:0] hrdata;
  logic hready, hresp, dq_out, dq_oe, sense_en, drive_low, spu, dq_lvl;
  logic [2:0] pin_out, pin_oe, pdn;
  int error_cnt = 0;
  int samples_checked = 0;

  always #2 core_clk = ~core_clk;
  assign dq_lvl = ~(drive_low | dq_oe);

  tsense_top #(.CONVERSION_TRIGGER_IN_CYCLES_P(CONVERSION_TRIGGER_IN), .SAMPLE_CYCLES_P(SAMPLE), .DEPTH(FIFO_DEPTH), .SERIAL_CODE(SERIAL)) tsense_top_i (
    .CORE_CLK(core_clk), .RESETN(resetn), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .DQ_IN(dq_lvl), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
    .GENERAL_PIN_ZERO_IN(strap[0] & ~pin_oe[0]), .GENERAL_PIN_ZERO_OUT(pin_out[0]), .GENERAL_PIN_ZERO_OE(pin_oe[0]),
    .GENERAL_PIN_ONE_IN(strap[1] & ~pin_oe[1]), .GENERAL_PIN_ONE_OUT(pin_out[1]), .GENERAL_PIN_ONE_OE(pin_oe[1]),
    .GENERAL_PIN_TWO_IN(strap[2] & ~pin_oe[2]), .GENERAL_PIN_TWO_OUT(pin_out[2]), .GENERAL_PIN_TWO_OE(pin_oe[2]),
    .PIN_PULLDOWN_EN(pdn), .TEMP_RAW(temp_raw), .SENSE_EN(sense_en));

  wire_master_model #(.SAMPLE(SAMPLE)) wire_master_model_i (
    .clk(core_clk), .line_lvl(dq_lvl), .converting(sense_en), .drive_low(drive_low), .strong_pullup(spu));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Address phase, then data phase; each held until hready is sampled high
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) begin
        error_cnt++;
        final_report();
      end
      // Data phase follows the first accepted edge only; each signal moves once per step
      if (ph == 0) begin
        htrans <= 2'h0;
        hwdata <= wd;
      end
    end
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, d, rd);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0, rd);
    check(name, rd, exp);
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  // Measures the busy pulse; a restarted conversion would show as a longer one
  task automatic wait_conversion_trigger_in(input logic run);
    int w;
    int n;
    w = 0;
    n = 0;
    while (sense_en !== 1'b1 && w < 1000) begin
      @(posedge core_clk);
      w++;
    end
    while (sense_en === 1'b1 && n < 1000) begin
      @(posedge core_clk);
      n++;
      if (n == CONVERSION_TRIGGER_IN / 2) begin
        check("strong_pullup", {31'h0, spu}, 32'h1);
      end
    end
    check("conversion_trigger_in_cycles", 32'(n), run ? 32'(CONVERSION_TRIGGER_IN) : 32'h0);
    check("dq_released", {30'h0, dq_out, dq_oe}, 32'h0);
    // An expected conversion that never starts or never ends ends the run
    if (run && (w >= 1000 || n >= 1000)) begin
      error_cnt++;
      final_report();
    end
    cycles(3);
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    cycles(10);
    resetn <= 1'b1;
    cycles(8);
  endtask

  initial begin
    do_reset();
    check("sense_idle", {31'h0, sense_en}, 32'h0);
    rd_chk("status", STATUS_OFS, 32'h8);
    rd_chk("count", FIFO_COUNT_OFS, 32'h0);
    rd_chk("setup", PIN_SETUP_OFS, {26'h0, PIN_SETUP_RST});
    rd_chk("pin_out", PIN_OUT_OFS, 32'h7);
    check("pulldown", {29'h0, pdn}, 32'h7);
    rd_chk("int_en", INT_EN_OFS, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    wr(SERIAL_LO_OFS, 32'h0);
    rd_chk("serial_lo", SERIAL_LO_OFS, SERIAL[31:0]);
    rd_chk("serial_hi", SERIAL_HI_OFS, SERIAL[63:32]);
    wr(UPPER_THR_OFS, 32'h1234);
    wr(LOWER_THR_OFS, 32'hfedc);
    rd_chk("upper_wr", UPPER_THR_OFS, 32'h1234);
    rd_chk("lower_wr", LOWER_THR_OFS, 32'hfedc);
    // Thresholds do not survive a second reset
    do_reset();
    rd_chk("upper_rst", UPPER_THR_OFS, 32'h7fff);
    rd_chk("lower_rst", LOWER_THR_OFS, 32'h8000);
    // Second start lands while the first is running
    temp_raw <= 16'hff38;
    wr(CTRL_OFS, 32'h1);
    wr(CTRL_OFS, 32'h1);
    wait_conversion_trigger_in(1'b1);
    rd_chk("count_one", FIFO_COUNT_OFS, 32'h1);
    rd_chk("neg_word", FIFO_DATA_OFS, 32'hff38);
    rd_chk("empty_rd", FIFO_DATA_OFS, 32'h0);
    // 0x22 read MSB first would look like the convert code
    temp_raw <= 16'h1ce8;
    fork
      wire_master_model_i.send_byte(8'h22);
      wait_conversion_trigger_in(1'b0);
    join
    fork
      wire_master_model_i.send_byte(CMD_CONVERT);
      wait_conversion_trigger_in(1'b1);
    join
    rd_chk("cmd_word", FIFO_DATA_OFS, 32'h1ce8);
    // Pin one edge ignored in its default role
    strap <= 3'h2;
    wait_conversion_trigger_in(1'b0);
    strap <= 3'h0;
    wr(PIN_SETUP_OFS, 32'h2e);
    cycles(10);
    temp_raw <= 16'h0001;
    strap <= 3'h2;
    wait_conversion_trigger_in(1'b1);
    rd_chk("edge_word", FIFO_DATA_OFS, 32'h1);
    // Alarm above the upper threshold drives pin zero low
    wr(UPPER_THR_OFS, 32'h1000);
    wr(INT_EN_OFS, 32'h1);
    wr(PIN_SETUP_OFS, 32'h2b);
    temp_raw <= 16'h1ce8;
    wr(CTRL_OFS, 32'h1);
    wait_conversion_trigger_in(1'b1);
    check("irq_on", {31'h0, pin_oe[0]}, 32'h1);
    wr(PIN_SETUP_OFS, 32'h2a);
    cycles(2);
    check("irq_role", {31'h0, pin_oe[0]}, 32'h0);
    rd_chk("status_hi", STATUS_OFS, 32'h2);
    rd_chk("irq_word", FIFO_DATA_OFS, 32'h1ce8);
    rd_chk("status_clr", STATUS_OFS, 32'h8);
    wr(PIN_SETUP_OFS, 32'h15);
    wr(PIN_OUT_OFS, 32'h2);
    cycles(2);
    check("od_out", {29'h0, pin_oe}, 32'h5);
    check("od_level", {29'h0, pin_out}, 32'h0);
    wr(PIN_SETUP_OFS, 32'h0);
    for (int v = 0; v < 8; v++) begin
      strap <= v[2:0];
      cycles(8);
      rd_chk("location", PIN_LEVEL_OFS, 32'(v));
    end
    for (int i = 0; i < 33; i++) begin
      temp_raw <= 16'h0100 + 16'(i);
      wr(CTRL_OFS, 32'h1);
      wait_conversion_trigger_in(1'b1);
    end
    rd_chk("full_count", FIFO_COUNT_OFS, 32'h20);
    for (int i = 1; i < 33; i++) begin
      rd_chk("fifo_order", FIFO_DATA_OFS, 32'h100 + 32'(i));
    end
    rd_chk("drained", FIFO_COUNT_OFS, 32'h0);
    final_report();
  end
endmodule
